/* File: core/ssp_spi_port.sv */
// file: spi-mode register interface and shifter of the serial port
//
// What this block does
// - status, control one/three, buffer, reload, shifter
// - control one fully readable and writable
// - status low six read-only, top two writable
// - reload register sets master clock rate
// - shifter shifts out and in together
// - software writes and reads the data buffer
// - finished byte copied to buffer, flag raised
// - buffer write loads buffer and shifter together
// - port active only while enable set
// - status bit0 shows buffer full
// - status bit6 picks master output launch edge
// - status bit7 picks master sample point
`timescale 1ns/100ps
module ssp_spi_port
    import ssp_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    input  wire ssp_sw_t    sw_i,
    input  wire logic       sck_i,
    input  wire logic       sdi_i,
    input  wire logic       ss_n_i,
    output logic [7:0]      serial_status_reg_o,
    output logic [7:0]      serial_control_one_o,
    output logic [7:0]      serial_control_three_o,
    output logic [7:0]      serial_data_buffer_o,
    output logic [7:0]      serial_address_reload_o,
    output logic            serial_irq_flag_o,
    output logic            busy_o,
    output ssp_pins_t       pins_o
);

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [1:0] {SSP_IDLE, SSP_LEAD, SSP_TRAIL} ssp_phase_t;

    typedef struct packed {
        logic [7:0]  stat_hi;
        logic        full;
        logic [7:0]  con1;
        logic [7:0]  con3;
        logic [7:0]  buf_q;
        logic [7:0]  add;
        logic [7:0]  sr;
        logic [3:0]  bits;
        ssp_phase_t  ph;
        logic        smp_pend;
        logic        irq;
        logic        sck_q;
        logic        sdo;
        logic        sck_in_q;
    } ssp_state_t;

    ssp_state_t st_r;
    ssp_state_t st_nxt;

    logic       enabled;
    logic       master;
    logic       tick;
    logic [3:0] mode;
    logic       ckp;
    logic       cke;
    logic       input_sample_phase;
    logic       slave_act;
    logic       sck_lvl;
    logic       lead_edge;
    logic       trail_edge;

    assign mode    = st_r.con1[3:0];
    assign ckp     = st_r.con1[CON1_CKP_BIT];
    assign cke     = st_r.stat_hi[STAT_EDGE_BIT];
    assign input_sample_phase     = st_r.stat_hi[STAT_SMP_BIT];
    assign enabled = st_r.con1[CON1_EN_BIT];
    assign master  = (mode == MODE_MASTER_DIV4) || (mode == MODE_MASTER_BRG);

    ssp_brg #(.W(8)) u_brg (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .run_i     (enabled && master && st_r.ph != SSP_IDLE),
        .reload_i  ((mode == MODE_MASTER_BRG) ? st_r.add : DIV4_RELOAD),
        .tick_o    (tick)
    );

    // slave edges on the incoming clock, relative to idle level
    assign slave_act  = (mode == MODE_SLAVE_NOSS) || !ss_n_i;
    assign sck_lvl    = sck_i ^ ckp;
    assign lead_edge  = sck_lvl && !st_r.sck_in_q;
    assign trail_edge = !sck_lvl && st_r.sck_in_q;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_nxt          = st_r;
        st_nxt.irq      = 1'b0;
        st_nxt.sck_in_q = sck_lvl;

        if (sw_i.wr_con1) begin
            st_nxt.con1 = sw_i.wdata;
        end
        if (sw_i.wr_con3) begin
            st_nxt.con3 = sw_i.wdata;
        end
        if (sw_i.wr_add) begin
            st_nxt.add = sw_i.wdata;
        end
        if (sw_i.wr_stat) begin
            st_nxt.stat_hi = sw_i.wdata & STAT_RW_MASK;
        end
        if (sw_i.rd_buf) begin
            st_nxt.full = 1'b0;
        end

        if (!enabled) begin
            st_nxt.ph    = SSP_IDLE;
            st_nxt.bits  = '0;
            st_nxt.full  = 1'b0;
            st_nxt.sck_q = 1'b0;
        end else begin
            if (sw_i.wr_buf && st_r.ph == SSP_IDLE && st_r.bits == '0) begin
                st_nxt.buf_q = sw_i.wdata;
                st_nxt.sr    = sw_i.wdata;
                st_nxt.sdo   = cke ? sw_i.wdata[7] : st_r.sdo;
                if (master) begin
                    st_nxt.ph = SSP_LEAD;
                end
            end
            if (master && st_r.ph != SSP_IDLE && tick) begin
                if (st_r.ph == SSP_LEAD) begin
                    // leading edge: launch when cke clear, sample when input_sample_phase clear
                    st_nxt.sck_q = 1'b1;
                    st_nxt.ph    = SSP_TRAIL;
                    if (!cke) begin
                        st_nxt.sdo = st_r.sr[7];
                    end
                    if (!input_sample_phase) begin
                        st_nxt.smp_pend = 1'b1;
                    end
                end else begin
                    // trailing edge: clock returns to idle; stops here only once an early-sampled byte has completed
                    st_nxt.sck_q = 1'b0;
                    if (!input_sample_phase && !st_r.smp_pend && st_r.bits == '0) begin
                        st_nxt.ph = SSP_IDLE;
                    end else begin
                        st_nxt.ph = SSP_LEAD;
                    end
                end
            end
            if (!master && slave_act && (lead_edge || trail_edge)) begin
                st_nxt.smp_pend = (lead_edge != cke);
            end
        end

        if (enabled && (st_r.smp_pend || (master && input_sample_phase && tick && st_r.ph == SSP_TRAIL))) begin
            st_nxt.smp_pend = 1'b0;
            st_nxt.sr       = {st_r.sr[6:0], sdi_i};
            st_nxt.bits     = st_r.bits + 4'h1;
            if (cke) begin
                st_nxt.sdo = st_r.sr[6];
            end
            if (st_r.bits + 4'h1 == BITS_PER_XFER) begin
                st_nxt.bits = '0;
                // master mid-sample waits for the trailing edge, else clock stays active
                if (!master || tick) begin
                    st_nxt.ph = SSP_IDLE;
                end
                st_nxt.buf_q = {st_r.sr[6:0], sdi_i};
                st_nxt.full  = 1'b1;
                st_nxt.irq   = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            st_r    <= '0;
            st_r.ph <= SSP_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // register views
    assign serial_status_reg_o     = {st_r.stat_hi[7:6], 5'h00, st_r.full};
    assign serial_control_one_o    = st_r.con1;
    assign serial_control_three_o  = st_r.con3;
    assign serial_data_buffer_o    = st_r.buf_q;
    assign serial_address_reload_o = st_r.add;
    assign serial_irq_flag_o       = st_r.irq;
    assign busy_o                  = st_r.ph != SSP_IDLE || st_r.bits != '0;
    assign pins_o.sck    = st_r.sck_q ^ ckp;
    assign pins_o.sdo    = st_r.sdo;
    assign pins_o.sdo_oe = enabled && (master || slave_act);
    assign pins_o.sck_oe = enabled && master;

endmodule

/* File: core/ssp_pkg.sv */
// package: constants and carrier types for the synchronous serial port
package ssp_pkg;

    // ****************************************
    // status register layout
    // ****************************************
    localparam int STAT_FULL_BIT    = 0;
    localparam int STAT_EDGE_BIT    = 6;
    localparam int STAT_SMP_BIT     = 7;
    localparam logic [7:0] STAT_RW_MASK = 8'hC0;

    // ****************************************
    // control register one layout
    // ****************************************
    localparam int CON1_EN_BIT      = 5;
    localparam int CON1_CKP_BIT     = 4;
    localparam logic [3:0] MODE_MASTER_DIV4 = 4'h0;
    localparam logic [3:0] MODE_MASTER_BRG  = 4'hA;
    localparam logic [3:0] MODE_SLAVE_SS    = 4'h4;
    localparam logic [3:0] MODE_SLAVE_NOSS  = 4'h5;

    // ****************************************
    // reset values and counts
    // ****************************************
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [3:0] BITS_PER_XFER = 4'h8;
    localparam logic [7:0] DIV4_RELOAD   = 8'h01;

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic       wr_stat;
        logic       wr_con1;
        logic       wr_con3;
        logic       wr_buf;
        logic       wr_add;
        logic       rd_buf;
        logic [7:0] wdata;
    } ssp_sw_t;

    typedef struct packed {
        logic sck;
        logic sdo;
        logic sdo_oe;
        logic sck_oe;
    } ssp_pins_t;

endpackage

/* File: core/ssp_brg.sv */
// file: serial clock rate generator
`timescale 1ns/100ps
module ssp_brg
    import ssp_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         sys_clk_i,
    input  wire logic         resetn_i,
    input  wire logic         run_i,
    input  wire logic [W-1:0] reload_i,
    output logic              tick_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } ssp_brg_t;

    ssp_brg_t st_r;
    ssp_brg_t st_nxt;

    // half-period tick every reload+1 cycles
    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (!run_i) begin
            st_nxt.cnt = reload_i;
        end else if (st_r.cnt == '0) begin
            st_nxt.cnt  = reload_i;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt - W'(1);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_o = st_r.tick;
endmodule

/* File: tb/ssp_spi_port_properties.sv */
// checker: port-level properties of the spi-mode serial port
`timescale 1ns/100ps
module ssp_spi_port_props
    import ssp_pkg::*;
(
    input wire logic       sys_clk_i,
    input wire logic       resetn_i,
    input wire ssp_sw_t    sw_i,
    input wire logic [7:0] serial_status_reg_o,
    input wire logic [7:0] serial_control_one_o,
    input wire logic [7:0] serial_data_buffer_o,
    input wire logic       serial_irq_flag_o,
    input wire logic       busy_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_start;
        sw_i.wr_buf && !busy_o && serial_control_one_o[CON1_EN_BIT];
    endsequence
    sequence s_run;
        busy_o [*8];
    endsequence
    chk_stat_low_ro: assert property (serial_status_reg_o[5:1] == 5'h00)
        else $error("status low bits not zero");
    chk_stat_top_rw: assert property (sw_i.wr_stat |=>
        serial_status_reg_o[7:6] == $past(sw_i.wdata[7:6])) else $error("status top bits");
    chk_con1_rw: assert property (sw_i.wr_con1 |=>
        serial_control_one_o == $past(sw_i.wdata)) else $error("control one readback");
    chk_buf_load: assert property (s_start |=>
        serial_data_buffer_o == $past(sw_i.wdata) && busy_o) else $error("buffer load");
    chk_refuse_off: assert property (sw_i.wr_buf && !serial_control_one_o[CON1_EN_BIT]
        |=> $stable(serial_data_buffer_o)) else $error("write taken while disabled");
    chk_irq_full: assert property (serial_irq_flag_o |->
        serial_status_reg_o[STAT_FULL_BIT]) else $error("flag without full");
    chk_irq_pulse: assert property (serial_irq_flag_o |=> !serial_irq_flag_o)
        else $error("flag longer than one cycle");
    chk_read_clear: assert property (sw_i.rd_buf ##1 !serial_irq_flag_o
        |-> !serial_status_reg_o[STAT_FULL_BIT]) else $error("full not cleared");
    chk_xfer_len: assert property ($rose(busy_o) |-> s_run ##[1:400] serial_irq_flag_o)
        else $error("transfer too short or never ends");
endmodule

/* File: tb/ssp_peer.sv */
// partner: spi slave peer, launch on falling, sample on rising
`timescale 1ns/100ps
module ssp_peer (
    input  wire logic       sclk_i,
    input  wire logic       mosi_i,
    input  wire logic       sel_i,
    input  wire logic       load_i,
    input  wire logic [7:0] tx_i,
    output logic            miso_o,
    output logic [7:0]      rx_o
);
    logic [7:0] sr_r  = 8'h00;
    logic       smp_r = 1'b0;
    logic [7:0] rx_r  = 8'h00;
    always @(posedge sclk_i) smp_r <= mosi_i;
    always @(posedge sclk_i) rx_r <= {rx_r[6:0], mosi_i};
    always @(negedge sclk_i or posedge load_i) begin
        if (load_i) sr_r <= tx_i;
        else sr_r <= {sr_r[6:0], smp_r};
    end
    // released line shows inverse so a stale bit never matches
    assign miso_o = sel_i ? sr_r[7] : ~sr_r[7];
    assign rx_o   = rx_r;
endmodule

/* File: tb/ssp_spi_port_bench.sv */
// bench: self-checking test of the spi-mode serial port
`timescale 1ns/100ps
module ssp_spi_port_bench
    import ssp_pkg::*;
;
    localparam logic [5:0] WST = 6'h20, WC1 = 6'h10, WC3 = 6'h08;
    localparam logic [5:0] WBF = 6'h04, WAD = 6'h02, RBF = 6'h01;
    logic       sys_clk_i = 1'b0, resetn_i = 1'b0, load = 1'b0, sel = 1'b0;
    ssp_sw_t    sw = '0;
    logic [7:0] ptx = 8'h00, prx, st, c1, c3, bf, ad;
    logic       irq, busy, miso, sck_w;
    ssp_pins_t  pins;
    int         miscompares = 0, total_checks = 0, n, len0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    // no master drives the clock wire: pull-down level
    assign sck_w = pins.sck_oe ? pins.sck : 1'b0;
    ssp_spi_port dut_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sw_i(sw), .sck_i(sck_w),
        .sdi_i(miso), .ss_n_i(1'b1), .serial_status_reg_o(st), .serial_control_one_o(c1),
        .serial_control_three_o(c3), .serial_data_buffer_o(bf), .serial_address_reload_o(ad),
        .serial_irq_flag_o(irq), .busy_o(busy), .pins_o(pins));
    ssp_peer peer_u (.sclk_i(sck_w), .mosi_i(pins.sdo), .sel_i(sel), .load_i(load),
        .tx_i(ptx), .miso_o(miso), .rx_o(prx));
    // ****************************************
    // tasks
    // ****************************************
    task automatic end_sim;
        if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic sw_op(input logic [5:0] s, input logic [7:0] d);
        @(negedge sys_clk_i);
        sw = {s, d};
        @(negedge sys_clk_i);
        sw = '0;
    endtask
    task automatic xfer(input logic [7:0] d, input logic [7:0] p, output int len);
        ptx = p;
        load = 1'b1;
        @(negedge sys_clk_i);
        load = 1'b0;
        sel = 1'b1;
        sw_op(WBF, d);
        cmp(bf, d);
        sw_op(WBF, 8'h77);
        len = 0;
        while (irq !== 1'b1 && len < 400) begin
            @(negedge sys_clk_i);
            len++;
        end
        sel = 1'b0;
        cmp(len < 400, 1);
        cmp(bf, p);
        cmp(st, 8'h41);
        cmp(prx, d);
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        resetn_i = 1'b1;
        cmp({st, c1, c3, bf, ad}, 40'h0);
        sw_op(WST, 8'hFF); cmp(st, 8'hC0);
        sw_op(WC1, 8'h1A); cmp(c1, 8'h1A);
        sw_op(WC3, 8'h5A); cmp(c3, 8'h5A);
        sw_op(WAD, 8'h02); cmp(ad, 8'h02);
        sw_op(WST, 8'h40);
        sw_op(WC1, 8'h00);
        sw_op(WBF, 8'h11); cmp(bf, 8'h00);
        sw_op(WC1, 8'h20);
        xfer(8'h3C, 8'hA5, len0);
        sw_op(RBF, 8'h00); cmp(st, 8'h40);
        sw_op(WC1, 8'h0A);
        sw_op(WC1, 8'h2A);
        xfer(8'hC3, 8'h5A, n);
        cmp(n > len0, 1);
        end_sim;
    end
    initial begin
        #(5 * 4000);
        miscompares++;
        end_sim;
    end
endmodule
bind ssp_spi_port ssp_spi_port_props chk_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .sw_i(sw_i), .serial_status_reg_o(serial_status_reg_o),
    .serial_control_one_o(serial_control_one_o), .serial_data_buffer_o(serial_data_buffer_o),
    .serial_irq_flag_o(serial_irq_flag_o), .busy_o(busy_o));
